// *** pkg/pfmux_consts.svh ***
/*
  Offsets, field positions, reset values and thresholds of the
  port pin function multiplexer.
  Assumes AXI4-Lite byte addressing, one 32-bit word per register.
*/
// Summary of operation
// - P1.0/P1.1 digital only while their analog buffer disable bit is 0
// - P1.0 drives timer output 0, feeds capture 0A; P1.1 drives MCLK, 0B
// - P1.2-P1.5 become segments 31-28 at count 05h; P1.6/P1.7 27/26 at 04h
// - P1.2 timer out 1/capture 1A, P1.3 supervisor, P1.4 low, P1.5 ACLK
// - P1.6/P1.7 direction from serial unit, carrying SPI data both ways
// - P2.0/P2.1 become segments 25/24 at count 04h, port below it
// - P2.0 timer out 2/capture 2A; P2.1 serial clock, serial direction
// - Seven byte registers per port from index 020h and 028h
`ifndef PFMUX_CONSTS_SVH
`define PFMUX_CONSTS_SVH

`define PF_IDX_P1_IN      6'h20
`define PF_IDX_P1_OUT     6'h21
`define PF_IDX_P1_DIR     6'h22
`define PF_IDX_P1_FLAG    6'h23
`define PF_IDX_P1_IES     6'h24
`define PF_IDX_P1_IE      6'h25
`define PF_IDX_P1_SEL     6'h26
`define PF_IDX_P2_IN      6'h28
`define PF_IDX_P2_OUT     6'h29
`define PF_IDX_P2_DIR     6'h2a
`define PF_IDX_P2_FLAG    6'h2b
`define PF_IDX_P2_IES     6'h2c
`define PF_IDX_P2_IE      6'h2d
`define PF_IDX_P2_SEL     6'h2e
`define PF_IDX_ABD        6'h30
`define PF_IDX_LCD_CNT    6'h31

`define PF_IDX_LSB        2
`define PF_IDX_MSB        7

`define PF_RST_BYTE       8'h00
`define PF_RST_PAIR       2'h0
`define PF_LCD_LOW_THR    8'h05
`define PF_LCD_HIGH_THR   8'h04
`define PF_MODDIR_MASK    10'h2c0
`define PF_RESP_OKAY      2'h0
`define PF_RESP_SLVERR    2'h2

`endif

// *** pkg/pfmux_pkg.sv ***
/*
  Types of the port pin function multiplexer.
  Assumes the constants header is included by every user.
*/
package pfmux_pkg;
    typedef struct packed {
        logic       aw_held, w_held, awready, wready, arready;
        logic       bvalid, rvalid;
        logic [1:0] bresp, rresp;
        logic [5:0] aw_idx;
        logic [7:0] wbyte;
        logic       wlane;
        logic [7:0] rdata;
        logic [7:0] p1_out, p1_dir, p1_flag, p1_ies, p1_ie, p1_sel;
        logic [1:0] p2_out, p2_dir, p2_flag, p2_ies, p2_ie, p2_sel;
        logic [1:0] abd;
        logic [7:0] lcd_cnt;
        logic [9:0] pad_out, pad_oe;
        logic [7:0] seg_own;
        logic [7:0] to_periph;
        logic       irq;
    } pfmux_state_t;
endpackage : pfmux_pkg

// *** pkg/pfmux_pin_if.sv ***
/*
  Carrier for filtered pin levels and edge pulses.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface pfmux_pin_if #(parameter int N = 10);
    logic [N-1:0] level;
    logic [N-1:0] rise;
    logic [N-1:0] fall;
    modport src  (output level, rise, fall);
    modport sink (input  level, rise, fall);
endinterface : pfmux_pin_if

// *** core/pfmux_sync.sv ***
/*
  Three-stage pin synchroniser with agreement filter and edge pulses.
  Assumes pad inputs are asynchronous to aclk.
*/
`timescale 1ns/1ps
module pfmux_sync
    import pfmux_pkg::*;
#(
    parameter int N = 10
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [N-1:0] pad_in,
    pfmux_pin_if.src          pins
);

    typedef struct packed {
        logic [N-1:0] s1, s2, s3, level, rise, fall;
    } pfmux_sync_t;

    pfmux_sync_t sync_reg;
    pfmux_sync_t sync_next;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        sync_next    = sync_reg;
        sync_next.s1 = pad_in;
        sync_next.s2 = sync_reg.s1;
        sync_next.s3 = sync_reg.s2;
        // Only agreeing late stages count, so one glitch is dropped
        for (int i = 0; i < N; i++) begin
            if (sync_reg.s2[i] == sync_reg.s3[i]) begin
                sync_next.level[i] = sync_reg.s2[i];
            end
        end
        sync_next.rise = sync_next.level & ~sync_reg.level;
        sync_next.fall = ~sync_next.level & sync_reg.level;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign pins.level = sync_reg.level;
    assign pins.rise  = sync_reg.rise;
    assign pins.fall  = sync_reg.fall;
endmodule : pfmux_sync

// *** core/pfmux_top.sv ***
/*
  Port 1 / port 2 pin function multiplexer with AXI4-Lite registers.
  Assumes peripheral signals are already on aclk; pads are not.
*/
`timescale 1ns/1ps
`include "pfmux_consts.svh"
module pfmux_top
    import pfmux_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    input  wire logic [9:0]  pad_in,
    output logic [9:0]       pad_out,
    output logic [9:0]       pad_oe,
    input  wire logic        timer_out0,
    input  wire logic        timer_out1,
    input  wire logic        timer_out2,
    input  wire logic        mclk_in,
    input  wire logic        aclk_in,
    input  wire logic        supply_supervisor_flag_out,
    input  wire logic        spi_mosi_out,
    input  wire logic        spi_mosi_dir_ctrl,
    input  wire logic        spi_miso_out,
    input  wire logic        spi_miso_dir_ctrl,
    input  wire logic        serial_clock_out,
    input  wire logic        serial_clock_dir_ctrl,
    output logic             capture_in_0a,
    output logic             capture_in_0b,
    output logic             capture_in_1a,
    output logic             capture_in_2a,
    output logic             timer_ext_clock_in,
    output logic             spi_master_out_line,
    output logic             spi_master_in_line,
    output logic             serial_clock_line,
    output logic [7:0]       lcd_segment_owned,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////
    // Pad synchroniser

    pfmux_pin_if #(.N(10)) pins ();

    pfmux_sync #(
        .N      (10)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pad_in  (pad_in),
        .pins    (pins)
    );

    ////////////////////////////////////////////////////////////////////
    // Register decode

    function automatic logic reg_hit(input logic [5:0] idx);
        case (idx)
            `PF_IDX_P1_IN, `PF_IDX_P1_OUT, `PF_IDX_P1_DIR,
            `PF_IDX_P1_FLAG, `PF_IDX_P1_IES, `PF_IDX_P1_IE,
            `PF_IDX_P1_SEL, `PF_IDX_P2_IN, `PF_IDX_P2_OUT,
            `PF_IDX_P2_DIR, `PF_IDX_P2_FLAG, `PF_IDX_P2_IES,
            `PF_IDX_P2_IE, `PF_IDX_P2_SEL, `PF_IDX_ABD,
            `PF_IDX_LCD_CNT: reg_hit = 1'b1;
            default:         reg_hit = 1'b0;
        endcase
    endfunction : reg_hit

    function automatic logic [5:0] idx_of(input logic [31:0] addr);
        idx_of = addr[`PF_IDX_MSB:`PF_IDX_LSB];
    endfunction : idx_of

    ////////////////////////////////////////////////////////////////////
    // State

    pfmux_state_t st_reg;
    pfmux_state_t st_next;

    logic [9:0] dig_en;
    logic [9:0] sel_all;
    logic [9:0] dir_all;
    logic [9:0] out_all;
    logic [9:0] mod_out;
    logic [9:0] mod_dir;
    logic [9:0] pin_lvl;
    logic [9:0] flag_set;
    logic [9:0] ies_all;
    logic       do_write;
    logic [5:0] ar_idx;
    logic [7:0] rd_byte;

    ////////////////////////////////////////////////////////////////////
    // Pin routing

    always_comb begin
        // Analog disable cuts the digital path of the first two pins
        dig_en[0] = ~st_reg.abd[0];
        dig_en[1] = ~st_reg.abd[1];

        // Segment ownership shared by the count thresholds
        for (int i = 2; i < 6; i++) begin
            dig_en[i] = st_reg.lcd_cnt < `PF_LCD_LOW_THR;
        end
        dig_en[6] = st_reg.lcd_cnt < `PF_LCD_HIGH_THR;
        dig_en[7] = st_reg.lcd_cnt < `PF_LCD_HIGH_THR;

        dig_en[8] = st_reg.lcd_cnt < `PF_LCD_HIGH_THR;
        dig_en[9] = st_reg.lcd_cnt < `PF_LCD_HIGH_THR;

        sel_all = {st_reg.p2_sel, st_reg.p1_sel};
        dir_all = {st_reg.p2_dir, st_reg.p1_dir};
        out_all = {st_reg.p2_out, st_reg.p1_out};
        ies_all = {st_reg.p2_ies, st_reg.p1_ies};

        mod_out[0] = timer_out0;
        mod_out[1] = mclk_in;
        mod_out[2] = timer_out1;
        mod_out[3] = supply_supervisor_flag_out;
        mod_out[4] = 1'b0;
        mod_out[5] = aclk_in;
        mod_out[6] = spi_mosi_out;
        mod_out[7] = spi_miso_out;

        mod_out[8] = timer_out2;
        mod_out[9] = serial_clock_out;

        mod_dir    = dir_all;
        mod_dir[6] = spi_mosi_dir_ctrl;
        mod_dir[7] = spi_miso_dir_ctrl;
        mod_dir[9] = serial_clock_dir_ctrl;

        // Disconnected pins read low and raise no edge
        pin_lvl = pins.level & dig_en;

        for (int i = 0; i < 10; i++) begin
            flag_set[i] = dig_en[i] & (ies_all[i] ? pins.fall[i]
                                                  : pins.rise[i]);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register read data

    assign ar_idx = idx_of(s_axi_araddr);

    always_comb begin
        case (ar_idx)
            `PF_IDX_P1_IN:   rd_byte = pin_lvl[7:0];
            `PF_IDX_P1_OUT:  rd_byte = st_reg.p1_out;
            `PF_IDX_P1_DIR:  rd_byte = st_reg.p1_dir;
            `PF_IDX_P1_FLAG: rd_byte = st_reg.p1_flag;
            `PF_IDX_P1_IES:  rd_byte = st_reg.p1_ies;
            `PF_IDX_P1_IE:   rd_byte = st_reg.p1_ie;
            `PF_IDX_P1_SEL:  rd_byte = st_reg.p1_sel;

            `PF_IDX_P2_IN:   rd_byte = {6'h00, pin_lvl[9:8]};
            `PF_IDX_P2_OUT:  rd_byte = {6'h00, st_reg.p2_out};
            `PF_IDX_P2_DIR:  rd_byte = {6'h00, st_reg.p2_dir};
            `PF_IDX_P2_FLAG: rd_byte = {6'h00, st_reg.p2_flag};
            `PF_IDX_P2_IES:  rd_byte = {6'h00, st_reg.p2_ies};
            `PF_IDX_P2_IE:   rd_byte = {6'h00, st_reg.p2_ie};
            `PF_IDX_P2_SEL:  rd_byte = {6'h00, st_reg.p2_sel};

            `PF_IDX_ABD:     rd_byte = {6'h00, st_reg.abd};
            `PF_IDX_LCD_CNT: rd_byte = st_reg.lcd_cnt;
            default:         rd_byte = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Next state

    assign do_write = st_reg.aw_held & st_reg.w_held & ~st_reg.bvalid;

    always_comb begin
        st_next = st_reg;

        // Write address and data are caught in either order
        if (s_axi_awvalid && st_reg.awready) begin
            st_next.aw_held = 1'b1;
            st_next.aw_idx  = idx_of(s_axi_awaddr);
        end

        if (s_axi_wvalid && st_reg.wready) begin
            st_next.w_held = 1'b1;
            st_next.wbyte  = s_axi_wdata[7:0];
            st_next.wlane  = s_axi_wstrb[0];
        end

        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end

        if (do_write) begin
            st_next.aw_held = 1'b0;
            st_next.w_held  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = reg_hit(st_reg.aw_idx) ? `PF_RESP_OKAY
                                                     : `PF_RESP_SLVERR;
        end

        // Register stores; flags are write-one-to-clear
        if (do_write && st_reg.wlane) begin
            case (st_reg.aw_idx)
                `PF_IDX_P1_OUT:  st_next.p1_out = st_reg.wbyte;
                `PF_IDX_P1_DIR:  st_next.p1_dir = st_reg.wbyte;
                `PF_IDX_P1_FLAG: st_next.p1_flag = st_reg.p1_flag
                                                   & ~st_reg.wbyte;
                `PF_IDX_P1_IES:  st_next.p1_ies = st_reg.wbyte;
                `PF_IDX_P1_IE:   st_next.p1_ie  = st_reg.wbyte;
                `PF_IDX_P1_SEL:  st_next.p1_sel = st_reg.wbyte;

                `PF_IDX_P2_OUT:  st_next.p2_out = st_reg.wbyte[1:0];
                `PF_IDX_P2_DIR:  st_next.p2_dir = st_reg.wbyte[1:0];
                `PF_IDX_P2_FLAG: st_next.p2_flag = st_reg.p2_flag
                                                   & ~st_reg.wbyte[1:0];
                `PF_IDX_P2_IES:  st_next.p2_ies = st_reg.wbyte[1:0];
                `PF_IDX_P2_IE:   st_next.p2_ie  = st_reg.wbyte[1:0];
                `PF_IDX_P2_SEL:  st_next.p2_sel = st_reg.wbyte[1:0];

                `PF_IDX_ABD:     st_next.abd    = st_reg.wbyte[1:0];
                `PF_IDX_LCD_CNT: st_next.lcd_cnt = st_reg.wbyte;
                default:         st_next.lcd_cnt = st_reg.lcd_cnt;
            endcase
        end

        // Hardware set beats a same-cycle clear
        st_next.p1_flag = st_next.p1_flag | flag_set[7:0];
        st_next.p2_flag = st_next.p2_flag | flag_set[9:8];

        // Read channel: one outstanding read
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end

        if (s_axi_arvalid && st_reg.arready) begin
            st_next.rvalid = 1'b1;
            st_next.rdata  = rd_byte;
            st_next.rresp  = reg_hit(ar_idx) ? `PF_RESP_OKAY
                                             : `PF_RESP_SLVERR;
        end

        st_next.awready = ~st_next.aw_held & ~st_next.bvalid;
        st_next.wready  = ~st_next.w_held & ~st_next.bvalid;
        st_next.arready = ~st_next.rvalid;

        // Pad drive; a disabled pin floats
        for (int i = 0; i < 10; i++) begin
            if (!dig_en[i]) begin
                st_next.pad_oe[i]  = 1'b0;
                st_next.pad_out[i] = 1'b0;
            end else if (sel_all[i]) begin
                st_next.pad_oe[i]  = mod_dir[i];
                st_next.pad_out[i] = mod_out[i];
            end else begin
                st_next.pad_oe[i]  = dir_all[i];
                st_next.pad_out[i] = out_all[i];
            end
        end

        // Segment 24+k owned by the LCD when the pin is not a port
        st_next.seg_own = {~dig_en[2], ~dig_en[3], ~dig_en[4],
                           ~dig_en[5], ~dig_en[6], ~dig_en[7],
                           ~dig_en[8], ~dig_en[9]};

        // Peripheral inputs only see the pin under function select
        st_next.to_periph[0] = sel_all[0] & pin_lvl[0];
        st_next.to_periph[1] = sel_all[1] & pin_lvl[1];
        st_next.to_periph[2] = sel_all[2] & pin_lvl[2];
        st_next.to_periph[3] = sel_all[8] & pin_lvl[8];
        st_next.to_periph[4] = sel_all[5] & pin_lvl[5];
        st_next.to_periph[5] = sel_all[6] & pin_lvl[6];
        st_next.to_periph[6] = sel_all[7] & pin_lvl[7];
        st_next.to_periph[7] = sel_all[9] & pin_lvl[9];

        st_next.irq = |({st_next.p2_flag, st_next.p1_flag}
                        & {st_next.p2_ie, st_next.p1_ie});
    end

    ////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg         <= '0;
            st_reg.awready <= 1'b1;
            st_reg.wready  <= 1'b1;
            st_reg.arready <= 1'b1;
            st_reg.p1_out  <= `PF_RST_BYTE;
            st_reg.p1_sel  <= `PF_RST_BYTE;
            st_reg.p2_sel  <= `PF_RST_PAIR;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops

    assign s_axi_awready      = st_reg.awready;
    assign s_axi_wready       = st_reg.wready;
    assign s_axi_bvalid       = st_reg.bvalid;
    assign s_axi_bresp        = st_reg.bresp;
    assign s_axi_arready      = st_reg.arready;
    assign s_axi_rvalid       = st_reg.rvalid;
    assign s_axi_rdata        = {24'h000000, st_reg.rdata};
    assign s_axi_rresp        = st_reg.rresp;

    assign pad_out            = st_reg.pad_out;
    assign pad_oe             = st_reg.pad_oe;

    assign capture_in_0a      = st_reg.to_periph[0];
    assign capture_in_0b      = st_reg.to_periph[1];
    assign capture_in_1a      = st_reg.to_periph[2];
    assign capture_in_2a      = st_reg.to_periph[3];
    assign timer_ext_clock_in = st_reg.to_periph[4];
    assign spi_master_out_line = st_reg.to_periph[5];
    assign spi_master_in_line = st_reg.to_periph[6];
    assign serial_clock_line  = st_reg.to_periph[7];

    assign lcd_segment_owned  = st_reg.seg_own;
    assign irq                = st_reg.irq;

endmodule : pfmux_top

// *** verif/pfmux_periph_model.sv ***
/*
  Stand-in for the timer, clock, supervisor and serial unit outputs.
  Assumes one clock shared with the mux; levels change after each edge.
*/
`timescale 1ns/1ps
module pfmux_periph_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    output logic      [11:0] periph
);
    // Bits: 0-2 timer, 3 mclk, 4 aclk, 5 supervisor, 6/7 mosi+dir,
    // 8/9 miso+dir, 10/11 serial clock+dir
    logic [15:0] lfsr_reg;
    logic        fb;
    assign fb = lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10];
    // Pseudo-random so a stuck route shows within a few cycles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lfsr_reg <= 16'h0001;
        end else begin
            lfsr_reg <= {lfsr_reg[14:0], fb};
        end
    end
    assign periph = lfsr_reg[11:0];
endmodule : pfmux_periph_model

// *** verif/pfmux_assertions.sv ***
/*
  Port-level checks of the pin function mux.
  Assumes binding to pfmux_top; all signals on aclk.
*/
`timescale 1ns/1ps
module pfmux_assertions (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic [9:0]  pad_in,
    input wire logic [9:0]  pad_out,
    input wire logic [9:0]  pad_oe,
    input wire logic        capture_in_0a,
    input wire logic        serial_clock_line,
    input wire logic [7:0]  lcd_segment_owned
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    chk_write_resp_time: assert property (wr_taken |=>
        !s_axi_bvalid ##1 s_axi_bvalid) else $error("late write response");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    chk_read_resp_time: assert property (rd_taken |=>
        s_axi_rvalid && !s_axi_arready) else $error("late read response");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    chk_unmapped_err: assert property (rd_taken ##0
        s_axi_araddr[7:2] > 6'h31 |=> s_axi_rresp == 2'h2 &&
        s_axi_rdata == 32'h0) else $error("unmapped read not refused");
    chk_byte_width: assert property (s_axi_rvalid |->
        s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
    chk_segment_groups: assert property (lcd_segment_owned inside
        {8'h00, 8'h0f, 8'hff}) else $error("segment groups split");
    chk_segment_upper: assert property (lcd_segment_owned[7] &&
        $past(lcd_segment_owned[7]) |-> pad_oe[5:2] == 4'h0 &&
        pad_out[5:2] == 4'h0) else $error("segment pin still driven");
    chk_segment_lower: assert property (lcd_segment_owned[0] &&
        $past(lcd_segment_owned[0]) |-> pad_oe[9:6] == 4'h0 &&
        pad_out[9:6] == 4'h0) else $error("segment pin still driven");
    chk_capture_level: assert property (capture_in_0a |->
        $past(pad_in[0], 3) || $past(pad_in[0], 4) || $past(pad_in[0], 5))
        else $error("capture without pin level");
    chk_sclk_level: assert property (serial_clock_line |->
        $past(pad_in[9], 3) || $past(pad_in[9], 4) || $past(pad_in[9], 5))
        else $error("serial clock without pin level");
endmodule : pfmux_assertions
bind pfmux_top pfmux_assertions pfmux_assertions_i (.*);

// *** verif/port1_port2_pin_function_mux_tb.sv ***
/*
  Self-checking bench: AXI4-Lite master, pad stimulus, peripheral model.
  Assumes the constants header is on the include path.
*/
`timescale 1ns/1ps
`include "pfmux_consts.svh"
module port1_port2_pin_function_mux_tb;
    logic        aclk = 1'b0, aresetn = 1'b0, hung = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
    logic [9:0]  pad_in = 10'h000, pad_out, pad_oe;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [11:0] periph;
    logic [7:0]  cap, lcd_segment_owned, v;
    logic [5:0]  rw [10] = '{6'h21, 6'h22, 6'h24, 6'h25, 6'h26,
                             6'h29, 6'h2a, 6'h2c, 6'h2d, 6'h2e};
    logic [33:0] expq [$];
    int          n_errors = 0, checks = 0;
    always #5 aclk = ~aclk;
    pfmux_periph_model pfmux_periph_model_i (.aclk(aclk),
        .aresetn(aresetn), .periph(periph));
    pfmux_top pfmux_top_i (.*, .s_axi_awprot(3'h0), .s_axi_arprot(3'h0),
        .s_axi_wstrb(4'hf), .timer_out0(periph[0]), .timer_out1(periph[1]),
        .timer_out2(periph[2]), .mclk_in(periph[3]), .aclk_in(periph[4]),
        .supply_supervisor_flag_out(periph[5]), .spi_mosi_out(periph[6]),
        .spi_mosi_dir_ctrl(periph[7]), .spi_miso_out(periph[8]),
        .spi_miso_dir_ctrl(periph[9]), .serial_clock_out(periph[10]),
        .serial_clock_dir_ctrl(periph[11]), .capture_in_0a(cap[0]),
        .capture_in_0b(cap[1]), .capture_in_1a(cap[2]),
        .timer_ext_clock_in(cap[3]), .spi_master_out_line(cap[4]),
        .spi_master_in_line(cap[5]), .capture_in_2a(cap[6]),
        .serial_clock_line(cap[7]));
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (n_errors == 0 && checks > 0 && !hung) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        int n;
        @(posedge aclk);
        s_axi_awaddr  <= {24'h0, idx, 2'h0};
        s_axi_wdata   <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, `PF_RESP_OKAY);
        if (n == 40) hung = 1'b1;
    endtask : wr
    task automatic rd(input logic [5:0] idx, input logic [7:0] d,
                      input logic [1:0] r);
        int n;
        @(posedge aclk);
        expq.push_back({r, 24'h0, d});
        s_axi_araddr  <= {24'h0, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        if (n == 40) hung = 1'b1;
    endtask : rd
    task automatic wait_n(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask : wait_n
    task automatic watch_mux();
        int          n;
        logic [11:0] p;
        @(negedge aclk);
        p = periph;
        for (n = 0; n < 16; n++) begin
            @(negedge aclk);
            check(pad_out, {p[10], p[2], p[8], p[6], p[4], 1'b0, p[5], p[1],
                p[3], p[0]});
            check(pad_oe, {p[11], 1'b1, p[9], p[7], 6'h3f});
            p = periph;
        end
    endtask : watch_mux
    ////////////////////////////////////////////////////////////////////////
    // Oldest expected read result against each completed read
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            if (expq.size() == 0) check(34'h1, 34'h0);
            else check({s_axi_rresp, s_axi_rdata}, expq.pop_front());
        end
        if (hung) test_done();
    end
    initial begin
        void'($urandom(32'h9ab5));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 6'h20; i <= 6'h31; i++) rd(6'(i), 8'h00,
            (i == 6'h27 || i == 6'h2f) ? `PF_RESP_SLVERR : `PF_RESP_OKAY);
        rd(6'h3f, 8'h00, `PF_RESP_SLVERR);
        foreach (rw[k]) begin
            v = 8'($urandom);
            wr(rw[k], v);
            rd(rw[k], rw[k][3] ? (v & 8'h03) : v, `PF_RESP_OKAY);
        end
        wr(`PF_IDX_P1_IN, 8'hff);
        rd(`PF_IDX_P1_IN, 8'h00, `PF_RESP_OKAY);
        // Plain port use: direction and output bits
        v = 8'($urandom);
        wr(`PF_IDX_P1_SEL, 8'h00);
        wr(`PF_IDX_P2_SEL, 8'h00);
        wr(`PF_IDX_P1_OUT, v);
        wr(`PF_IDX_P2_OUT, ~v);
        wr(`PF_IDX_P1_DIR, 8'hff);
        wr(`PF_IDX_P2_DIR, 8'h03);
        wait_n(3);
        check(pad_oe, 10'h3ff);
        check(pad_out, {~v[1:0], v});
        wr(`PF_IDX_P1_DIR, 8'h00);
        wr(`PF_IDX_P2_DIR, 8'h00);
        @(posedge aclk) pad_in <= 10'($urandom);
        wait_n(8);
        check(pad_oe, 10'h000);
        rd(`PF_IDX_P1_IN, pad_in[7:0], `PF_RESP_OKAY);
        rd(`PF_IDX_P2_IN, {6'h0, pad_in[9:8]}, `PF_RESP_OKAY);
        // Peripheral routing, then analog and segment takeover
        wr(`PF_IDX_P1_SEL, 8'hff);
        wr(`PF_IDX_P2_SEL, 8'h03);
        wr(`PF_IDX_P1_DIR, 8'hff);
        wr(`PF_IDX_P2_DIR, 8'h03);
        watch_mux();
        @(posedge aclk) pad_in <= 10'h3ff;
        wait_n(8);
        check(cap, 8'hff);
        wr(`PF_IDX_ABD, 8'h03);
        wait_n(8);
        check(cap[1:0], 2'h0);
        check(pad_oe[1:0], 2'h0);
        wr(`PF_IDX_LCD_CNT, 8'h04);
        wait_n(3);
        check(lcd_segment_owned, 8'h0f);
        check(cap, 8'h0c);
        wr(`PF_IDX_LCD_CNT, 8'h05);
        wait_n(3);
        check(lcd_segment_owned, 8'hff);
        check(pad_oe, 10'h000);
        wr(`PF_IDX_LCD_CNT, 8'h00);
        wr(`PF_IDX_ABD, 8'h00);
        // Edge flags, masking and clearing
        wr(`PF_IDX_P1_SEL, 8'h00);
        wr(`PF_IDX_P2_SEL, 8'h00);
        wr(`PF_IDX_P1_IE, 8'h00);
        wr(`PF_IDX_P2_IE, 8'h00);
        @(posedge aclk) pad_in <= 10'h000;
        wait_n(8);
        wr(`PF_IDX_P1_FLAG, 8'hff);
        wr(`PF_IDX_P2_FLAG, 8'h03);
        wr(`PF_IDX_P1_IES, 8'h01);
        wr(`PF_IDX_P2_IES, 8'h00);
        wr(`PF_IDX_P1_IE, 8'h01);
        @(posedge aclk) pad_in <= 10'h103;
        wait_n(8);
        check(irq, 1'b0);
        rd(`PF_IDX_P1_FLAG, 8'h02, `PF_RESP_OKAY);
        rd(`PF_IDX_P2_FLAG, 8'h01, `PF_RESP_OKAY);
        wr(`PF_IDX_P1_IE, 8'h03);
        wait_n(2);
        check(irq, 1'b1);
        wr(`PF_IDX_P1_FLAG, 8'h02);
        wait_n(2);
        check(irq, 1'b0);
        @(posedge aclk) pad_in <= 10'h102;
        wait_n(8);
        check(irq, 1'b1);
        rd(`PF_IDX_P1_FLAG, 8'h01, `PF_RESP_OKAY);
        wait_n(4);
        test_done();
    end
endmodule : port1_port2_pin_function_mux_tb
